// File: core/mcl_monitor_loop.sv
// How it works
// - A command acts only when a complete message is handed over with valid.
// - Identification request 80 00 answers 80 followed by the identification code.
// - Block error read answers the addressed port's count, then clears it.
// - Block error answer is two bytes, second byte the eight-bit count.
// - Relay set 81 7X drives the port's D, C, B, A pins from X.
// - Status read 81 00 answers 81 with the two status pins in bits 1:0.
// - Any status pin change sends the status answer unrequested.
// - Messages 87 xx are echoed unchanged with no other action.
// - Port registers are reached through the bank chosen by port select.
// - Deactivation or software reset clears measurement and three near-loop bits.
// - Measurement and loop register writes act on the next clock edge.
// - Measurement field 00 disables counting; 11 counts and sends zeros.
// - Framer loop bit loops user data at the converter boundary, always transparent.
// - Transparency 0 forwards looped data; 1 replaces it by all-ones idle.
// - Transparency bit has no effect on framer and analog loops.
// - Near loops toward system in transparent mode transmit only once transparent.
// - One direction bit: 0 loops system to system, 1 line to line.
// - Complete loop bit loops B1, B2 and D in the chosen direction.
// - B2 and B1 loop bits loop only their own channel.
// - Block error counter counts both code violations, saturates at 255, clears on read.
// - Bit error counter counts while enabled and clears on low byte read.
// - Port select low two bits choose port 0 to 3; upper bits read zero.
//
// Purpose: Monitor command interpreter and per-port maintenance registers.
// Assumes: Monitor handshake is done outside; complete messages arrive as pulses.
// Notes:   One answer is held at a time; commands stall while it waits.
`timescale 1ns/1ps
`default_nettype none
module mcl_monitor_loop
  import mcl_pkg::*;
#(
  parameter logic [7:0] IDENT_CODE = 8'h3c // Arbitrary identification value.
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        mon_cmd_valid,
  output logic             mon_cmd_ready,
  input  wire logic [1:0]  mon_cmd_port,
  input  wire logic [7:0]  mon_cmd_byte0,
  input  wire logic [7:0]  mon_cmd_byte1,
  output logic             mon_ans_valid,
  input  wire logic        mon_ans_ready,
  output logic [1:0]       mon_ans_port,
  output logic [7:0]       mon_ans_byte0,
  output logic [7:0]       mon_ans_byte1,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [3:0]  deactivating,
  input  wire logic [3:0]  sw_reset,
  input  wire logic [3:0]  line_transparent,
  input  wire logic [3:0]  near_code_viol,
  input  wire logic [3:0]  far_code_viol,
  input  wire logic [3:0]  bit_err,
  input  wire logic [3:0]  port_status_in_0,
  input  wire logic [3:0]  port_status_in_1,
  output logic [3:0]       relay_drive_a,
  output logic [3:0]       relay_drive_b,
  output logic [3:0]       relay_drive_c,
  output logic [3:0]       relay_drive_d,
  output logic [3:0]       send_zeros,
  output logic [3:0]       b1_loop_en,
  output logic [3:0]       b2_loop_en,
  output logic [3:0]       d_loop_en,
  output logic [3:0]       loop_toward_line,
  output logic [3:0]       framer_loop_en,
  output logic [3:0]       idle_subst_en,
  output logic [3:0]       line_tx_gate
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [3:0][7:0]  meas_r;
  logic [3:0][7:0]  loop_r;
  logic [3:0][7:0]  blk_r;
  logic [3:0][15:0] bit_err_counter_r;
  logic [3:0][3:0]  relay_r;
  logic [7:0]       sel_r;
  logic [3:0]       st0_s1_r, st0_s2_r, st1_s1_r, st1_s2_r, st0_prev_r, st1_prev_r;
  logic [3:0]       stat_pend_r;
  logic             ans_valid_r;
  logic [1:0]       ans_port_r;
  logic [7:0]       ans_b0_r, ans_b1_r;
  logic [7:0]       rdata_r;
  logic             rvalid_r;
  logic             cmd_take, is_ident, is_blk_rd, is_relay, is_stat, is_echo, is_known;
  logic [1:0]       sel_port, pend_port;
  logic [3:0]       blk_clr, bit_err_counter_clr, stat_change, ctl_clear;

  // Port number of the current register bank.
  assign sel_port = sel_r[1:0];

  // Returns one when the measurement field of a register enables counting.
  function automatic logic meas_enabled(input logic [7:0] v);
    meas_enabled = (v[MEAS_FIELD_HI:MEAS_FIELD_LO] == MEAS_ON);
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // A message is only taken when the answer slot is free, so no reply is lost.
  assign mon_cmd_ready = !ans_valid_r;
  assign cmd_take  = mon_cmd_valid && mon_cmd_ready;
  assign is_ident  = (mon_cmd_byte0 == MSG_GRP_80) && (mon_cmd_byte1 == ID_REQ_LO);
  assign is_blk_rd = (mon_cmd_byte0 == MSG_GRP_80) && (mon_cmd_byte1 == BLK_RD_LO);
  assign is_relay  = (mon_cmd_byte0 == MSG_GRP_81) && (mon_cmd_byte1[7:4] == RELAY_SET_HI);
  assign is_stat   = (mon_cmd_byte0 == MSG_GRP_81) && (mon_cmd_byte1 == STAT_REQ_LO);
  assign is_echo   = (mon_cmd_byte0 == MSG_ECHO);
  assign is_known  = is_ident || is_blk_rd || is_stat || is_echo;

  // Lowest-numbered port with a pending unrequested status report.
  always_comb begin
    pend_port = 2'd0;
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (stat_pend_r[p]) begin
        pend_port = p[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Answer slot
  // ----------------------------------------------------------------
  // Commands take priority; pending status reports fill idle slots.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ans_valid_r <= 1'b0;
      ans_port_r  <= 2'd0;
      ans_b0_r    <= 8'h00;
      ans_b1_r    <= 8'h00;
    end else if (cmd_take && is_known) begin
      ans_valid_r <= 1'b1;
      ans_port_r  <= mon_cmd_port;
      ans_b0_r    <= mon_cmd_byte0;
      if (is_ident) begin
        ans_b1_r <= IDENT_CODE;
      end else if (is_blk_rd) begin
        ans_b1_r <= blk_r[mon_cmd_port];
      end else if (is_stat) begin
        ans_b1_r <= {6'h00, st1_s2_r[mon_cmd_port], st0_s2_r[mon_cmd_port]};
      end else begin
        ans_b1_r <= mon_cmd_byte1;
      end
    end else if (ans_valid_r) begin
      if (mon_ans_ready) begin
        ans_valid_r <= 1'b0;
      end
    end else if (|stat_pend_r) begin
      ans_valid_r <= 1'b1;
      ans_port_r  <= pend_port;
      ans_b0_r    <= MSG_GRP_81;
      ans_b1_r    <= {6'h00, st1_s2_r[pend_port], st0_s2_r[pend_port]};
    end
  end
  assign mon_ans_valid = ans_valid_r;
  assign mon_ans_port  = ans_port_r;
  assign mon_ans_byte0 = ans_b0_r;
  assign mon_ans_byte1 = ans_b1_r;

  // ----------------------------------------------------------------
  // Status pins: synchronise, detect change, remember pending report
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st0_s1_r   <= 4'h0;
      st0_s2_r   <= 4'h0;
      st1_s1_r   <= 4'h0;
      st1_s2_r   <= 4'h0;
      st0_prev_r <= 4'h0;
      st1_prev_r <= 4'h0;
    end else begin
      st0_s1_r   <= port_status_in_0;
      st0_s2_r   <= st0_s1_r;
      st1_s1_r   <= port_status_in_1;
      st1_s2_r   <= st1_s1_r;
      st0_prev_r <= st0_s2_r;
      st1_prev_r <= st1_s2_r;
    end
  end
  assign stat_change = (st0_s2_r ^ st0_prev_r) | (st1_s2_r ^ st1_prev_r);

  // A change in the same cycle as the report leaving is kept pending.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stat_pend_r <= 4'h0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (stat_change[p]) begin
          stat_pend_r[p] <= 1'b1;
        end else if (!ans_valid_r && !(cmd_take && is_known) && pend_port == p[1:0]) begin
          stat_pend_r[p] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Relay drivers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      relay_r <= '0;
    end else if (cmd_take && is_relay) begin
      relay_r[mon_cmd_port] <= mon_cmd_byte1[3:0];
    end
  end
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      relay_drive_a[p] = relay_r[p][0];
      relay_drive_b[p] = relay_r[p][1];
      relay_drive_c[p] = relay_r[p][2];
      relay_drive_d[p] = relay_r[p][3];
    end
  end

  // ----------------------------------------------------------------
  // Control registers and port select
  // ----------------------------------------------------------------
  assign ctl_clear = deactivating | sw_reset;

  // Clears win over a write in the same cycle; writes act on the next clock edge.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sel_r  <= RST_SEL;
      meas_r <= {NUM_PORTS{RST_MEASURE}};
      loop_r <= {NUM_PORTS{RST_LOOP}};
    end else begin
      if (reg_wr && reg_addr == OFF_PORT_SEL) begin
        sel_r <= reg_wdata & SEL_MASK;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (ctl_clear[p]) begin
          meas_r[p] <= RST_MEASURE;
          loop_r[p] <= loop_r[p] & ~LOOP_CLR_MASK;
        end else if (reg_wr && sel_port == p[1:0]) begin
          if (reg_addr == OFF_MEASURE) begin
            meas_r[p] <= reg_wdata & MEAS_MASK;
          end
          if (reg_addr == OFF_LOOP) begin
            loop_r[p] <= (reg_wdata & LOOP_WR_MASK) | LOOP_FIX_ONES;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      blk_clr[p]  = (cmd_take && is_blk_rd && mon_cmd_port == p[1:0]) ||
                    (reg_rd && reg_addr == OFF_BLK_ERR && sel_port == p[1:0]);
      bit_err_counter_clr[p] = reg_rd && reg_addr == OFF_BIT_ERR_COUNTER_LO && sel_port == p[1:0];
    end
  end

  // An event that lands on the clearing read starts the new count.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      blk_r  <= {NUM_PORTS{RST_BLK_ERR}};
      bit_err_counter_r <= {NUM_PORTS{RST_BIT_ERR_COUNTER}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        logic [8:0]  bsum;
        logic [16:0] esum;
        bsum = (blk_clr[p] ? 9'h000 : {1'b0, blk_r[p]})
             + {8'h00, near_code_viol[p]} + {8'h00, far_code_viol[p]};
        blk_r[p] <= bsum[8] ? 8'hff : bsum[7:0];
        esum = (bit_err_counter_clr[p] ? 17'h00000 : {1'b0, bit_err_counter_r[p]})
             + {16'h0000, bit_err[p] && meas_enabled(meas_r[p])};
        bit_err_counter_r[p] <= esum[16] ? 16'hffff : esum[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          OFF_MEASURE:  rdata_r <= meas_r[sel_port];
          OFF_LOOP:     rdata_r <= loop_r[sel_port];
          OFF_BLK_ERR:  rdata_r <= blk_r[sel_port];
          OFF_BIT_ERR_COUNTER_LO:  rdata_r <= bit_err_counter_r[sel_port][7:0];
          OFF_BIT_ERR_COUNTER_HI:  rdata_r <= bit_err_counter_r[sel_port][15:8];
          OFF_PORT_SEL: rdata_r <= sel_r;
          default:      rdata_r <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ----------------------------------------------------------------
  // Loop and test controls toward the data path
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      send_zeros[p]       = meas_enabled(meas_r[p]);
      b1_loop_en[p]       = loop_r[p][LOOP_B1_BIT] | loop_r[p][LOOP_FULL_BIT];
      b2_loop_en[p]       = loop_r[p][LOOP_B2_BIT] | loop_r[p][LOOP_FULL_BIT];
      d_loop_en[p]        = loop_r[p][LOOP_FULL_BIT];
      loop_toward_line[p] = loop_r[p][LOOP_DIR_BIT];
      framer_loop_en[p]   = loop_r[p][LOOP_FRM_BIT];
      idle_subst_en[p]    = loop_r[p][LOOP_LOOP_TRANSPARENCY_BIT_BIT] &&
                            (b1_loop_en[p] || b2_loop_en[p]);
      line_tx_gate[p]     = !((b1_loop_en[p] || b2_loop_en[p]) && !loop_toward_line[p] &&
                            !loop_r[p][LOOP_LOOP_TRANSPARENCY_BIT_BIT]) || line_transparent[p];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_ident_answer: assert property (cmd_take && is_ident |=>
    ans_valid_r && ans_b0_r == MSG_GRP_80 && ans_b1_r == IDENT_CODE)
    else $error("identification answer wrong");
  a_blk_read: assert property (cmd_take && is_blk_rd && mon_cmd_port == 2'd1
    && !near_code_viol[1] && !far_code_viol[1] |=>
    ans_b1_r == $past(blk_r[1]) && blk_r[1] == 8'h00)
    else $error("block error read did not report and clear");
  a_blk_saturate: assert property (blk_r[0] == 8'hff && !blk_clr[0] |=>
    blk_r[0] == 8'hff)
    else $error("block error counter left saturation");
  a_relay_set: assert property (cmd_take && is_relay |=>
    relay_r[$past(mon_cmd_port)] == $past(mon_cmd_byte1[3:0]))
    else $error("relay pins not set from command");
  a_echo_copy: assert property (cmd_take && is_echo |=>
    ans_valid_r && ans_b0_r == MSG_ECHO && ans_b1_r == $past(mon_cmd_byte1))
    else $error("echo message altered");
  // A pending status report may legally fill the slot, so only quiet cycles are judged.
  a_unknown_drop: assert property (cmd_take && !is_known
    && stat_pend_r == 4'h0 |=> !ans_valid_r)
    else $error("reply sent for unknown command");
  a_deact_clear: assert property (ctl_clear[3] |=>
    meas_r[3] == 8'h00 && loop_r[3][2:0] == 3'h0 && loop_r[3][6:4] == $past(loop_r[3][6:4]))
    else $error("deactivation clear wrong");
  a_bit_err_counter_idle: assert property (!meas_enabled(meas_r[3]) && !bit_err_counter_clr[3] |=>
    $stable(bit_err_counter_r[3]))
    else $error("bit error counter moved while disabled");
  a_sel_upper: assert property (reg_rd && reg_addr == OFF_PORT_SEL |=>
    reg_rvalid && reg_rdata[7:2] == 6'h00)
    else $error("port select upper bits not zero");
  a_status_push: assert property (stat_change[3] && !ans_valid_r && !mon_cmd_valid
    && stat_pend_r[2:0] == 3'h0 |=> ##[0:2] ans_valid_r && ans_b0_r == MSG_GRP_81)
    else $error("status change not reported");

  c_ident: cover property (cmd_take && is_ident ##1 ans_valid_r);
  c_blk_sat: cover property (blk_r[0] == 8'hff);
  c_status_push: cover property (stat_change[3] ##[1:4] ans_valid_r && ans_port_r == 2'd3);
  c_measure: cover property (send_zeros[3] && bit_err[3]);
endmodule // mcl_monitor_loop
`default_nettype wire

// File: core/mcl_pkg.sv
// Purpose: Shared constants of the monitor command interpreter and loop register bank.
// Assumes: Four line ports, 8-bit register data, two-byte monitor messages.
// Notes:   Offsets are the register addresses seen by the register monitor protocol.
package mcl_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MEASURE  = 8'h0f;
  localparam logic [7:0] OFF_LOOP     = 8'h10;
  localparam logic [7:0] OFF_BLK_ERR  = 8'h12;
  localparam logic [7:0] OFF_BIT_ERR_COUNTER_LO  = 8'h13;
  localparam logic [7:0] OFF_BIT_ERR_COUNTER_HI  = 8'h14;
  localparam logic [7:0] OFF_PORT_SEL = 8'h1c;
  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MEASURE = 8'h00;
  localparam logic [7:0] RST_LOOP    = 8'h08;
  localparam logic [7:0] RST_BLK_ERR = 8'h00;
  localparam logic [15:0] RST_BIT_ERR_COUNTER   = 16'h0000;
  localparam logic [7:0] RST_SEL     = 8'h00;
  localparam int MEAS_FIELD_LO = 4;
  localparam int MEAS_FIELD_HI = 5;
  localparam logic [1:0] MEAS_ON  = 2'h3;
  localparam int LOOP_B1_BIT    = 0;
  localparam int LOOP_B2_BIT    = 1;
  localparam int LOOP_FULL_BIT  = 2;
  localparam int LOOP_DIR_BIT   = 4;
  localparam int LOOP_LOOP_TRANSPARENCY_BIT_BIT = 5;
  localparam int LOOP_FRM_BIT   = 6;
  localparam logic [7:0] LOOP_WR_MASK  = 8'h77;
  localparam logic [7:0] LOOP_FIX_ONES = 8'h08;
  localparam logic [7:0] LOOP_CLR_MASK = 8'h07;
  localparam logic [7:0] SEL_MASK      = 8'h03;
  localparam logic [7:0] MEAS_MASK     = 8'h30;
  // ----------------------------------------------------------------
  // Monitor message codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MSG_GRP_80   = 8'h80;
  localparam logic [7:0] MSG_GRP_81   = 8'h81;
  localparam logic [7:0] MSG_ECHO     = 8'h87;
  localparam logic [7:0] ID_REQ_LO    = 8'h00;
  localparam logic [7:0] BLK_RD_LO    = 8'hef;
  localparam logic [7:0] STAT_REQ_LO  = 8'h00;
  localparam logic [3:0] RELAY_SET_HI = 4'h7;
endpackage : mcl_pkg

// File: tb/mcl_host_model.sv
// Purpose: Host side of the monitor channel; accepts answers and keeps the last one.
// Assumes: The block holds each answer with valid until the host takes it.
// Notes:   A nonzero stall makes the host slow, so the block's one-answer slot stays busy.
`timescale 1ns/1ps
`default_nettype none
module mcl_host_model
  import mcl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [7:0]  stall,
  input  wire logic        mon_ans_valid,
  input  wire logic [1:0]  mon_ans_port,
  input  wire logic [7:0]  mon_ans_byte0,
  input  wire logic [7:0]  mon_ans_byte1,
  output logic             mon_ans_ready,
  output logic [17:0]      last_ans,
  output int               ans_count
);
  logic [7:0] wait_r;
  // Ready rises only while an answer waits, and drops at the edge that takes it.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mon_ans_ready <= 1'b0;
      wait_r        <= 8'h00;
      last_ans      <= 18'h00000;
      ans_count     <= 0;
    end else if (mon_ans_valid && mon_ans_ready) begin
      last_ans      <= {mon_ans_port, mon_ans_byte0, mon_ans_byte1};
      ans_count     <= ans_count + 1;
      mon_ans_ready <= 1'b0;
      wait_r        <= 8'h00;
    end else if (mon_ans_valid) begin
      wait_r        <= wait_r + 8'h01;
      mon_ans_ready <= (wait_r >= stall);
    end
  end
endmodule // mcl_host_model
`default_nettype wire

// File: tb/monitor_cmd_and_loop_regs_bench.sv
// Purpose: Self-checking bench for the monitor interpreter and loop register bank.
// Assumes: Status pins start low, so no status report follows reset.
// Notes:   Port bank 3 carries the loop and measurement scenarios.
`timescale 1ns/1ps
`default_nettype none
module monitor_cmd_and_loop_regs_bench;
  import mcl_pkg::*;
  localparam logic [7:0] ID_CODE = 8'h5a; // Arbitrary identification value.
  logic        mclk, nrst, mon_cmd_valid, mon_cmd_ready, mon_ans_valid, mon_ans_ready;
  logic        reg_wr, reg_rd, reg_rvalid;
  logic [1:0]  mon_cmd_port, mon_ans_port;
  logic [7:0]  mon_cmd_byte0, mon_cmd_byte1, mon_ans_byte0, mon_ans_byte1, stall;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  deactivating, sw_reset, line_transparent, near_code_viol, far_code_viol;
  logic [3:0]  bit_err, port_status_in_0, port_status_in_1, relay_drive_a, relay_drive_b;
  logic [3:0]  relay_drive_c, relay_drive_d, send_zeros, b1_loop_en, b2_loop_en, d_loop_en;
  logic [3:0]  loop_toward_line, framer_loop_en, idle_subst_en, line_tx_gate;
  logic [17:0] last_ans;
  int          ans_count, n0, fails, samples_checked;
  logic [7:0]  ra [7] = '{8'h0f, 8'h10, 8'h12, 8'h13, 8'h14, 8'h1c, 8'h20};
  logic [7:0]  rx [7] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  mcl_monitor_loop #(.IDENT_CODE(ID_CODE)) DUT (.mclk, .nrst, .mon_cmd_valid, .mon_cmd_ready,
    .mon_cmd_port,
    .mon_cmd_byte0, .mon_cmd_byte1, .mon_ans_valid, .mon_ans_ready, .mon_ans_port,
    .mon_ans_byte0, .mon_ans_byte1, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .deactivating, .sw_reset, .line_transparent, .near_code_viol,
    .far_code_viol, .bit_err, .port_status_in_0, .port_status_in_1, .relay_drive_a,
    .relay_drive_b, .relay_drive_c, .relay_drive_d, .send_zeros, .b1_loop_en, .b2_loop_en,
    .d_loop_en, .loop_toward_line, .framer_loop_en, .idle_subst_en, .line_tx_gate);
  mcl_host_model HOST (.mclk, .nrst, .stall, .mon_ans_valid, .mon_ans_port, .mon_ans_byte0,
    .mon_ans_byte1, .mon_ans_ready, .last_ans, .ans_count);

  // --------------------------------------------------------------
  // Clock, report and access tasks
  // --------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic timeout;
    fails++;
    $display("CHECK FAILED handshake expected done seen stuck");
    summarize();
  endtask
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  function automatic logic [3:0] rly(input int p);
    return {relay_drive_d[p], relay_drive_c[p], relay_drive_b[p], relay_drive_a[p]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // The read answer comes exactly one cycle later, so no open wait is needed.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    if (reg_rvalid !== 1'b1) timeout();
    chk($sformatf("reg %h", a), reg_rdata, e);
  endtask
  task automatic cmd(input logic [1:0] p, input logic [7:0] b0, input logic [7:0] b1);
    int i;
    @(posedge mclk);
    mon_cmd_valid <= 1'b1;
    mon_cmd_port <= p;
    mon_cmd_byte0 <= b0;
    mon_cmd_byte1 <= b1;
    for (i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (mon_cmd_ready === 1'b1) break;
    end
    @(posedge mclk);
    mon_cmd_valid <= 1'b0;
    if (i == 40) timeout();
  endtask
  task automatic ans(input logic [1:0] p, input logic [7:0] b0, input logic [7:0] b1);
    for (int i = 0; i < 40 && ans_count == n0; i++) @(negedge mclk);
    if (ans_count == n0) timeout();
    n0 = ans_count;
    chk("answer", last_ans, {p, b0, b1});
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {nrst, mon_cmd_valid, reg_wr, reg_rd, mon_cmd_port, mon_cmd_byte0, mon_cmd_byte1} = '0;
    {reg_addr, reg_wdata, stall, deactivating, sw_reset, line_transparent} = '0;
    {near_code_viol, far_code_viol, bit_err, port_status_in_0, port_status_in_1} = '0;
    n0 = 0;
    tick(3);
    nrst <= 1'b1;
    foreach (ra[k]) rc(ra[k], rx[k]);
    cmd(2'd0, 8'h80, 8'h00);
    ans(2'd0, 8'h80, ID_CODE);
    @(posedge mclk) stall <= 8'h03;
    cmd(2'd1, 8'h87, 8'h5a);
    ans(2'd1, 8'h87, 8'h5a);
    cmd(2'd0, 8'h82, 8'h11);
    cmd(2'd0, 8'h81, 8'h33);
    cmd(2'd2, 8'h81, 8'h7a);
    cmd(2'd1, 8'h81, 8'h75);
    tick(8);
    chk("silent", 18'(ans_count), 18'(n0));
    chk("relay 2", rly(2), 4'ha);
    chk("relay 1", rly(1), 4'h5);
    @(posedge mclk) port_status_in_0 <= 4'h8;
    ans(2'd3, 8'h81, 8'h01);
    cmd(2'd3, 8'h81, 8'h00);
    ans(2'd3, 8'h81, 8'h01);
    @(posedge mclk) port_status_in_1 <= 4'h8;
    ans(2'd3, 8'h81, 8'h03);
    @(posedge mclk) near_code_viol <= 4'h2;
    tick(3);
    near_code_viol <= 4'h0;
    far_code_viol <= 4'h2;
    tick(1);
    far_code_viol <= 4'h0;
    cmd(2'd1, 8'h80, 8'hef);
    ans(2'd1, 8'h80, 8'h04);
    cmd(2'd1, 8'h80, 8'hef);
    ans(2'd1, 8'h80, 8'h00);
    @(posedge mclk) near_code_viol <= 4'h1;
    tick(260);
    near_code_viol <= 4'h0;
    rc(OFF_BLK_ERR, 8'hff);
    rc(OFF_BLK_ERR, 8'h00);
    wr(OFF_PORT_SEL, 8'hff);
    rc(OFF_PORT_SEL, 8'h03);
    // Bank 3 until port select is set back to 0 at the end; the gate must hold until the line is transparent.
    wr(OFF_LOOP, 8'h04);
    @(negedge mclk);
    chk("gate", line_tx_gate[3], 1'b0);
    @(posedge mclk) line_transparent <= 4'h8;
    tick(1);
    @(negedge mclk);
    chk("gate", line_tx_gate[3], 1'b1);
    wr(OFF_LOOP, 8'h17);
    @(negedge mclk);
    chk("loops", {b1_loop_en, b2_loop_en, d_loop_en, loop_toward_line}, 16'h8888);
    rc(OFF_LOOP, 8'h1f);
    wr(OFF_LOOP, 8'h02);
    @(negedge mclk);
    chk("b2 only", {b1_loop_en, b2_loop_en, d_loop_en, loop_toward_line}, 16'h0800);
    wr(OFF_LOOP, 8'h21);
    @(negedge mclk);
    chk("idle", idle_subst_en, 4'h8);
    wr(OFF_LOOP, 8'h60);
    @(negedge mclk);
    chk("framer", {framer_loop_en, idle_subst_en, b1_loop_en}, 12'h800);
    rc(OFF_BIT_ERR_COUNTER_LO, 8'h00);
    wr(OFF_MEASURE, 8'h30);
    @(negedge mclk);
    chk("zeros", send_zeros, 4'h8);
    @(posedge mclk) bit_err <= 4'h8;
    tick(5);
    bit_err <= 4'h0;
    rc(OFF_BIT_ERR_COUNTER_HI, 8'h00);
    rc(OFF_BIT_ERR_COUNTER_LO, 8'h05);
    rc(OFF_BIT_ERR_COUNTER_LO, 8'h00);
    wr(OFF_MEASURE, 8'h10);
    @(posedge mclk) bit_err <= 4'h8;
    tick(3);
    bit_err <= 4'h0;
    rc(OFF_BIT_ERR_COUNTER_LO, 8'h00);
    chk("zeros", send_zeros, 4'h0);
    wr(OFF_MEASURE, 8'h30);
    wr(OFF_LOOP, 8'h37);
    @(posedge mclk) deactivating <= 4'h8;
    @(posedge mclk) deactivating <= 4'h0;
    rc(OFF_LOOP, 8'h38);
    rc(OFF_MEASURE, 8'h00);
    wr(OFF_LOOP, 8'h07);
    @(posedge mclk) sw_reset <= 4'h8;
    @(posedge mclk) sw_reset <= 4'h0;
    rc(OFF_LOOP, 8'h08);
    wr(OFF_PORT_SEL, 8'h00);
    rc(OFF_LOOP, 8'h08);
    summarize();
  end
endmodule // monitor_cmd_and_loop_regs_bench
`default_nettype wire
